// file: bgdp_regs.vh
// Constants of the background debug command port: command codes,
// status/control bit positions and bit-level timing counts.
// Assumes one debug controller clock; every count is in its cycles.
`ifndef BGDP_REGS_VH
`define BGDP_REGS_VH

// Command codes
`define BGDP_ACK_ON 8'hd5
`define BGDP_ACK_OFF 8'hd6
`define BGDP_BGND 8'h90
`define BGDP_STAT_RD 8'he4
`define BGDP_CTRL_WR 8'hc4
`define BGDP_MEM_RD 8'he0
`define BGDP_MEM_RDS 8'he1
`define BGDP_LAST_RD 8'he8
`define BGDP_MEM_WR 8'hc0
`define BGDP_MEM_WRS 8'hc1
`define BGDP_MATCH_RD 8'he2
`define BGDP_MATCH_WR 8'hc2
`define BGDP_RESUME 8'h08
`define BGDP_RESUME_TAG 8'h18
`define BGDP_STEP 8'h10
`define BGDP_ACC_RD 8'h68
`define BGDP_FLAGS_RD 8'h69
`define BGDP_CTR_RD 8'h6b
`define BGDP_IDX_RD 8'h6c
`define BGDP_STK_RD 8'h6f
`define BGDP_INC_RD 8'h70
`define BGDP_INC_RDS 8'h71
`define BGDP_ACC_WR 8'h48
`define BGDP_FLAGS_WR 8'h49
`define BGDP_CTR_WR 8'h4b
`define BGDP_IDX_WR 8'h4c
`define BGDP_STK_WR 8'h4f
`define BGDP_INC_WR 8'h50
`define BGDP_INC_WRS 8'h51

// Status/control byte layout and reset value
`define BGDP_SC_ENABLE 7
`define BGDP_SC_HALTED 6
`define BGDP_SC_RESET 8'h00

// CPU register selects
`define BGDP_SEL_ACC 3'h0
`define BGDP_SEL_FLAGS 3'h1
`define BGDP_SEL_CTR 3'h2
`define BGDP_SEL_IDX 3'h3
`define BGDP_SEL_STK 3'h4

// Timing counts in debug clock cycles
`define BGDP_SAMPLE 8'h0a
`define BGDP_ONE_PULSE 8'h07
`define BGDP_ZERO_LOW 8'h0d
`define BGDP_DELAY 5'h10
`define BGDP_TIMEOUT 10'h200
`define BGDP_SYNC_DETECT 8'h80
`define BGDP_SYNC_GAP 8'h10
`define BGDP_SYNC_LOW 8'h80

`endif

// file: bgdp_link.v
// Bit-level engine of the single-wire debug line: receive sampling,
// transmit drive with speedup pulses, timeout and speed-reference reply.
// Assumes the line is pulled up outside and the host starts every bit.
`timescale 1ns/10ps
`include "bgdp_regs.vh"

module bgdp_link (
	// Clock and reset
	input wire sys_clk,
	input wire arst_n,
	// Debug line pin
	input wire line_in,
	output reg line_out,
	output reg line_oe,
	// Command layer side
	input wire send,
	input wire send_bit,
	output reg bit_done,
	output reg bit_val,
	output reg abort
);
	localparam L_IDLE = 3'h0;
	localparam L_BIT = 3'h1;
	localparam L_SYNCW = 3'h2;
	localparam L_SYNCD = 3'h3;
	localparam L_SYNCL = 3'h4;
	localparam L_SYNCH = 3'h5;

	reg s1, s2, s3;
	reg [2:0] st;
	reg [7:0] cnt;
	reg [7:0] lcnt;
	reg [9:0] tcnt;
	reg dir, txb;
	wire fall = s3 & ~s2;
	wire in_sync = (st == L_SYNCW) || (st == L_SYNCD) || (st == L_SYNCL) || (st == L_SYNCH);

	// Two-stage synchroniser; only s3 and s2 feed logic
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
		end else begin
			s1 <= line_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Bit engine, low-time watch and sync reply
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= L_IDLE;
			cnt <= 8'h00;
			lcnt <= 8'h00;
			tcnt <= 10'h000;
			dir <= 1'b0;
			txb <= 1'b0;
			line_out <= 1'b0;
			line_oe <= 1'b0;
			bit_done <= 1'b0;
			bit_val <= 1'b0;
			abort <= 1'b0;
		end else begin
			bit_done <= 1'b0;
			abort <= 1'b0;
			// Own drive never counts as host low time
			lcnt <= (s2 | line_oe | in_sync) ? 8'h00 : lcnt + 8'h01;
			tcnt <= fall ? 10'h000 : (tcnt == `BGDP_TIMEOUT - 10'h001) ? tcnt : tcnt + 10'h001;
			if (!fall && tcnt == `BGDP_TIMEOUT - 10'h002)
				abort <= 1'b1; // [RL23]
			if (!in_sync && !s2 && lcnt == `BGDP_SYNC_DETECT - 8'h01) begin
				st <= L_SYNCW; // [RL20]
				abort <= 1'b1;
				line_oe <= 1'b0;
			end else begin
				case (st)
				L_IDLE: begin
					if (fall) begin
						st <= L_BIT;
						cnt <= 8'h00;
						dir <= send;
						txb <= send_bit;
						if (send && !send_bit) begin
							line_oe <= 1'b1; // [RL25]
							line_out <= 1'b0;
						end
					end
				end
				L_BIT: begin
					cnt <= cnt + 8'h01;
					if (!dir && cnt == `BGDP_SAMPLE) begin
						bit_val <= s2; // [RL24]
						bit_done <= 1'b1;
						st <= L_IDLE;
					end
					if (dir && txb) begin
						if (cnt == `BGDP_ONE_PULSE - 8'h01) begin
							line_oe <= 1'b1; // [RL26]
							line_out <= 1'b1;
						end
						if (cnt == `BGDP_ONE_PULSE)
							line_oe <= 1'b0;
						if (cnt == `BGDP_SAMPLE) begin
							bit_done <= 1'b1;
							st <= L_IDLE;
						end
					end
					if (dir && !txb) begin
						if (cnt == `BGDP_ZERO_LOW - 8'h01)
							line_out <= 1'b1; // [RL25]
						if (cnt == `BGDP_ZERO_LOW) begin
							line_oe <= 1'b0;
							bit_done <= 1'b1;
							st <= L_IDLE;
						end
					end
				end
				L_SYNCW: begin
					cnt <= 8'h00;
					if (s2)
						st <= L_SYNCD; // [RL22]
				end
				L_SYNCD: begin
					cnt <= cnt + 8'h01;
					if (cnt == `BGDP_SYNC_GAP - 8'h01) begin
						line_oe <= 1'b1;
						line_out <= 1'b0;
						cnt <= 8'h00;
						st <= L_SYNCL;
					end
				end
				L_SYNCL: begin
					cnt <= cnt + 8'h01;
					if (cnt == `BGDP_SYNC_LOW - 8'h01) begin
						line_out <= 1'b1; // [RL22]
						st <= L_SYNCH;
					end
				end
				L_SYNCH: begin
					line_oe <= 1'b0;
					st <= L_IDLE;
				end
				default: st <= L_IDLE;
				endcase
			end
		end
	end
endmodule

// file: bgdp_cmd.v
// Command layer of the background debug port: decodes command codes
// from the debug line and performs memory, register and mode actions.
// Assumes CPU and memory run on sys_clk; mem_rdata is valid the cycle
// after a mem_rd pulse; the debug line is synchronised in bgdp_link.
//
// Contract
// [RL1] Codes and fields travel most significant bit first
// [RL2] Host waits sixteen cycles at each delay
// [RL3] Non-intrusive anytime; others only while halted
// [RL4] Host sends 16-bit address after memory codes
// [RL5] Byte and word data fields, both directions
// [RL6] Status field out, control byte in
// [RL7] Enter halt on request if enable set
// [RL8] Switch acknowledge handshake on or off
// [RL9] Read or write status/control byte
// [RL10] Read memory byte, optionally status first
// [RL11] Status then re-read last read address
// [RL12] Write memory byte, optionally status after
// [RL13] Read or write 16-bit breakpoint match
// [RL14] Resume user program, tagged variant identical
// [RL15] Execute one instruction then halt again
// [RL16] Return accumulator, flags, counter, index, stack
// [RL17] Load accumulator, flags, counter, index, stack
// [RL18] Increment index then read byte there
// [RL19] Increment index then write byte there
// [RL20] Detect speed request by long low only
// [RL21] Host holds low at least 128 slow cycles
// [RL22] Reply: wait high, 16, low 128, pulse
// [RL23] 512 idle cycles abandon any command
// [RL24] Sample host bit ten cycles after start
// [RL25] Zero bit: low thirteen cycles, then pulse
// [RL26] One bit: speedup pulse seven cycles in
// [RL27] Discard halted-only commands while program runs
`timescale 1ns/10ps
`include "bgdp_regs.vh"

module bgdp_cmd (
	// Clock and reset
	input wire sys_clk,
	input wire arst_n,
	// Debug line pin
	input wire line_in,
	output wire line_out,
	output wire line_oe,
	// CPU state
	input wire cpu_halted,
	input wire [7:0] cpu_acc,
	input wire [7:0] cpu_flags,
	input wire [15:0] cpu_pc,
	input wire [15:0] cpu_index,
	input wire [15:0] cpu_sp,
	// CPU register writes and mode requests
	output reg reg_wr,
	output reg [2:0] reg_sel,
	output reg [15:0] reg_wdata,
	output reg bgnd_req,
	output reg go_req,
	output reg step_req,
	// Memory access
	output reg [15:0] mem_addr,
	output reg [7:0] mem_wdata,
	output reg mem_rd,
	output reg mem_wr,
	input wire [7:0] mem_rdata,
	// Debug controller state
	output reg ack_enable,
	output reg [7:0] debug_status_control,
	output reg [15:0] debug_breakpoint_match
);
	localparam P_CODE = 3'h0;
	localparam P_ADDR = 3'h1;
	localparam P_WDAT = 3'h2;
	localparam P_DLY = 3'h3;
	localparam P_STAT = 3'h4;
	localparam P_RDAT = 3'h5;

	// Field map per command: bit n set means phase n follows,
	// bit 6 is a 16-bit write field, bit 7 a 16-bit read field
	function [7:0] fields;
		input [7:0] c;
		input h;
		begin
			fields = 8'h00;
			case (c)
			`BGDP_ACK_ON, `BGDP_ACK_OFF, `BGDP_BGND: fields = 8'h08;
			`BGDP_STAT_RD: fields = 8'h10;
			`BGDP_CTRL_WR: fields = 8'h04;
			`BGDP_MEM_RD: fields = 8'h2a;
			`BGDP_MEM_RDS: fields = 8'h3a;
			`BGDP_LAST_RD: fields = 8'h30;
			`BGDP_MEM_WR: fields = 8'h0e;
			`BGDP_MEM_WRS: fields = 8'h1e;
			`BGDP_MATCH_RD: fields = 8'ha0;
			`BGDP_MATCH_WR: fields = 8'h44;
			`BGDP_RESUME, `BGDP_RESUME_TAG, `BGDP_STEP: fields = h ? 8'h08 : 8'h00;
			`BGDP_ACC_RD, `BGDP_FLAGS_RD, `BGDP_INC_RD: fields = h ? 8'h28 : 8'h00;
			`BGDP_CTR_RD, `BGDP_IDX_RD, `BGDP_STK_RD: fields = h ? 8'ha8 : 8'h00;
			`BGDP_INC_RDS: fields = h ? 8'h38 : 8'h00;
			`BGDP_ACC_WR, `BGDP_FLAGS_WR, `BGDP_INC_WR: fields = h ? 8'h0c : 8'h00;
			`BGDP_CTR_WR, `BGDP_IDX_WR, `BGDP_STK_WR: fields = h ? 8'h4c : 8'h00;
			`BGDP_INC_WRS: fields = h ? 8'h1c : 8'h00;
			default: fields = 8'h00;
			endcase
		end
	endfunction

	// First phase after cur that the command uses, else back to code
	function [2:0] next_ph;
		input [7:0] f;
		input [2:0] cur;
		integer i;
		begin
			next_ph = P_CODE;
			for (i = 5; i >= 1; i = i - 1) begin
				if (i > cur && f[i])
					next_ph = i[2:0];
			end
		end
	endfunction

	// CPU register addressed by a register read or write code
	function [2:0] regsel;
		input [7:0] c;
		begin
			case (c[3:0])
			4'h9: regsel = `BGDP_SEL_FLAGS;
			4'hb: regsel = `BGDP_SEL_CTR;
			4'hc: regsel = `BGDP_SEL_IDX;
			4'hf: regsel = `BGDP_SEL_STK;
			default: regsel = `BGDP_SEL_ACC;
			endcase
		end
	endfunction

	reg [2:0] phase;
	reg [4:0] bits;
	reg load;
	reg [7:0] code;
	reg [7:0] flg;
	reg [15:0] shift;
	reg [15:0] wbuf;
	reg [15:0] last_addr;
	reg [7:0] rbuf;
	reg rd_pend;
	reg [7:0] status;
	reg [15:0] rd_val;
	reg [4:0] len;
	wire bit_done, bit_val, abort;
	wire [15:0] rx_word = {shift[14:0], bit_val};
	wire [7:0] f_new = fields(rx_word[7:0], cpu_halted);
	wire [15:0] idx_inc = cpu_index + 16'h0001;
	wire sending = (phase == P_STAT) || (phase == P_RDAT);

	// Line engine: bit timing, timeout and speed-reference reply
	bgdp_link u_link (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.line_in(line_in),
		.line_out(line_out),
		.line_oe(line_oe),
		.send(sending),
		.send_bit(shift[15]),
		.bit_done(bit_done),
		.bit_val(bit_val),
		.abort(abort)
	);

	// Status view: the halted bit always reflects the CPU, not the store
	always @* begin
		status = debug_status_control;
		status[`BGDP_SC_HALTED] = cpu_halted; // [RL6]
	end

	// Read data source for the outgoing data field
	always @* begin
		case (code)
		`BGDP_MATCH_RD: rd_val = debug_breakpoint_match; // [RL13]
		`BGDP_ACC_RD, `BGDP_FLAGS_RD, `BGDP_CTR_RD, `BGDP_IDX_RD, `BGDP_STK_RD: begin
			case (regsel(code)) // [RL16]
			`BGDP_SEL_FLAGS: rd_val = {cpu_flags, 8'h00};
			`BGDP_SEL_CTR: rd_val = cpu_pc;
			`BGDP_SEL_IDX: rd_val = cpu_index;
			`BGDP_SEL_STK: rd_val = cpu_sp;
			default: rd_val = {cpu_acc, 8'h00};
			endcase
		end
		default: rd_val = {rbuf, 8'h00};
		endcase
	end

	// Bit length of the current phase; delay counts cycles instead
	always @* begin
		case (phase)
		P_ADDR: len = 5'h10; // [RL4]
		P_WDAT: len = flg[6] ? 5'h10 : 5'h08; // [RL5]
		P_DLY: len = `BGDP_DELAY; // [RL2]
		P_RDAT: len = flg[7] ? 5'h10 : 5'h08;
		default: len = 5'h08;
		endcase
	end

	// Command sequencer
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase <= P_CODE;
			bits <= 5'h00;
			load <= 1'b0;
			code <= 8'h00;
			flg <= 8'h00;
			shift <= 16'h0000;
			wbuf <= 16'h0000;
			last_addr <= 16'h0000;
			rbuf <= 8'h00;
			rd_pend <= 1'b0;
			reg_wr <= 1'b0;
			reg_sel <= `BGDP_SEL_ACC;
			reg_wdata <= 16'h0000;
			bgnd_req <= 1'b0;
			go_req <= 1'b0;
			step_req <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			ack_enable <= 1'b0;
			debug_status_control <= `BGDP_SC_RESET;
			debug_breakpoint_match <= 16'h0000;
		end else begin
			reg_wr <= 1'b0;
			bgnd_req <= 1'b0;
			go_req <= 1'b0;
			step_req <= 1'b0;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			load <= 1'b0;
			// Memory answers one cycle after the strobe
			rd_pend <= mem_rd;
			if (rd_pend)
				rbuf <= mem_rdata;
			if (abort) begin
				// Nothing is written before the last field is in
				phase <= P_CODE; // [RL23]
				bits <= 5'h00;
			end else if (load) begin
				// Entry actions of the phase just reached
				case (phase)
				P_CODE: begin
					if (code == `BGDP_CTRL_WR)
						debug_status_control <= wbuf[7:0]; // [RL9]
					if (code == `BGDP_MATCH_WR)
						debug_breakpoint_match <= wbuf; // [RL13]
				end
				P_DLY: begin
					case (code)
					`BGDP_BGND: bgnd_req <= debug_status_control[`BGDP_SC_ENABLE]; // [RL7]
					`BGDP_ACK_ON: ack_enable <= 1'b1; // [RL8]
					`BGDP_ACK_OFF: ack_enable <= 1'b0; // [RL8]
					`BGDP_RESUME, `BGDP_RESUME_TAG: go_req <= 1'b1; // [RL14]
					`BGDP_STEP: step_req <= 1'b1; // [RL15]
					`BGDP_MEM_RD, `BGDP_MEM_RDS: begin
						mem_rd <= 1'b1; // [RL10]
						last_addr <= mem_addr;
					end
					`BGDP_MEM_WR, `BGDP_MEM_WRS: begin
						mem_wr <= 1'b1; // [RL12]
						mem_wdata <= wbuf[7:0];
					end
					`BGDP_INC_RD, `BGDP_INC_RDS, `BGDP_INC_WR, `BGDP_INC_WRS: begin
						reg_wr <= 1'b1; // [RL18] [RL19]
						reg_sel <= `BGDP_SEL_IDX;
						reg_wdata <= idx_inc;
						mem_addr <= idx_inc;
						mem_wdata <= wbuf[7:0];
						if (code[5]) begin
							mem_rd <= 1'b1;
							last_addr <= idx_inc;
						end else begin
							mem_wr <= 1'b1;
						end
					end
					`BGDP_ACC_WR, `BGDP_FLAGS_WR: begin
						reg_wr <= 1'b1; // [RL17]
						reg_sel <= regsel(code);
						reg_wdata <= {8'h00, wbuf[7:0]};
					end
					`BGDP_CTR_WR, `BGDP_IDX_WR, `BGDP_STK_WR: begin
						reg_wr <= 1'b1; // [RL17]
						reg_sel <= regsel(code);
						reg_wdata <= wbuf;
					end
					default: reg_wr <= 1'b0;
					endcase
				end
				P_STAT: shift <= {status, 8'h00}; // [RL6]
				P_RDAT: shift <= flg[7] ? rd_val : {rd_val[15:8], 8'h00}; // [RL5]
				default: shift <= shift;
				endcase
			end else if (phase == P_DLY) begin
				// Access time: count the delay, then move on
				bits <= bits + 5'h01;
				if (bits == len - 5'h01) begin
					phase <= next_ph(flg, phase);
					bits <= 5'h00;
					load <= 1'b1;
				end
			end else if (bit_done) begin
				// One bit in or out, most significant first
				shift <= rx_word; // [RL1]
				bits <= bits + 5'h01;
				if (bits == len - 5'h01) begin
					bits <= 5'h00;
					load <= 1'b1;
					case (phase)
					P_CODE: begin
						code <= rx_word[7:0];
						flg <= f_new; // [RL3] [RL27]
						phase <= next_ph(f_new, P_CODE);
						if (rx_word[7:0] == `BGDP_LAST_RD) begin
							mem_rd <= 1'b1; // [RL11]
							mem_addr <= last_addr;
						end
					end
					P_ADDR: begin
						mem_addr <= rx_word; // [RL4]
						phase <= next_ph(flg, phase);
					end
					P_WDAT: begin
						wbuf <= rx_word; // [RL5]
						phase <= next_ph(flg, phase);
					end
					default: phase <= next_ph(flg, phase);
					endcase
				end
			end
		end
	end
endmodule

// file: bgdp_cmd_chk.sv
// Checker for the debug command port: line drive shapes and strobe relations
// Assumes it is bound to bgdp_cmd and sees only its ports
`timescale 1ns/10ps
module bgdp_cmd_chk (
	// Clock and reset
	input wire sys_clk,
	input wire arst_n,
	// Debug line drive
	input wire line_out,
	input wire line_oe,
	// Strobes and state
	input wire cpu_halted,
	input wire reg_wr,
	input wire [2:0] reg_sel,
	input wire [15:0] reg_wdata,
	input wire bgnd_req,
	input wire go_req,
	input wire step_req,
	input wire [15:0] mem_addr,
	input wire mem_rd,
	input wire mem_wr,
	input wire [7:0] debug_status_control
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic [7:0] low_cnt;
	// Length of the present low drive; a counter keeps the property short
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			low_cnt <= 8'h00;
		else
			low_cnt <= (line_oe && !line_out) ? low_cnt + 8'h01 : 8'h00;
	end
	property p_low_len;
		line_oe && line_out && $past(line_oe) && !$past(line_out) |-> (low_cnt == 8'h0d || low_cnt == 8'h80);
	endproperty
	a_low_len: assert property (p_low_len) else $error("low drive length wrong");
	property p_pulse_rel;
		line_oe && line_out |=> !line_oe;
	endproperty
	a_pulse_rel: assert property (p_pulse_rel) else $error("speedup pulse not one cycle");
	property p_bgnd_gate;
		bgnd_req |-> debug_status_control[7];
	endproperty
	a_bgnd_gate: assert property (p_bgnd_gate) else $error("halt request while disabled");
	property p_halted_only;
		reg_wr || go_req || step_req |-> cpu_halted;
	endproperty
	a_halted_only: assert property (p_halted_only) else $error("halted-only action while running");
	property p_wr_excl;
		mem_wr |-> !mem_rd && !line_oe;
	endproperty
	a_wr_excl: assert property (p_wr_excl) else $error("write overlaps read or drive");
	property p_idx_pair;
		reg_wr && reg_sel == 3'h3 && (mem_rd || mem_wr) |-> mem_addr == reg_wdata;
	endproperty
	a_idx_pair: assert property (p_idx_pair) else $error("index access address mismatch");
	property p_rd_settle;
		mem_rd |=> $stable(mem_addr);
	endproperty
	a_rd_settle: assert property (p_rd_settle) else $error("read address moved");
	property p_mode_excl;
		go_req || step_req |-> !bgnd_req && !(go_req && step_req);
	endproperty
	a_mode_excl: assert property (p_mode_excl) else $error("mode requests overlap");
	c_sync: cover property (low_cnt == 8'h80);
	c_idx: cover property (reg_wr && mem_rd);
	c_bgnd: cover property (bgnd_req);
endmodule
bind bgdp_cmd bgdp_cmd_chk u_chk (.sys_clk, .arst_n, .line_out, .line_oe, .cpu_halted, .reg_wr, .reg_sel,
	.reg_wdata, .bgnd_req, .go_req, .step_req, .mem_addr, .mem_rd, .mem_wr, .debug_status_control);

// file: bgdp_pod.sv
// Host pod model: starts every bit on the debug line, sends and reads fields
// Assumes the bench resolves the wire with a pull-up; runs on its own time
`timescale 1ns/10ps
module bgdp_pod (
	// Debug line
	input wire line,
	output reg pod_low
);
	logic [15:0] rx_val;
	int slow = 0;
	event rx_ev;
	initial pod_low = 1'b0;
	// Short low sends or reads a one, long low sends a zero
	task automatic bit_io(input logic b, output logic s);
		pod_low = 1'b1;
		#(b ? 30 : 140) pod_low = 1'b0;
		#(b ? 90 : 0) s = line;
		#((b ? 80 : 60) + slow);
	endtask
	// Field toward the device, top bit first
	task automatic send(input logic [15:0] v, input int n);
		logic s;
		for (int i = n - 1; i >= 0; i--) bit_io(v[i], s);
	endtask
	// Field from the device, top bit first
	task automatic recv(input int n);
		logic s;
		logic [15:0] v;
		v = 16'h0000;
		for (int i = 0; i < n; i++) begin
			bit_io(1'b1, s);
			v = {v[14:0], s};
		end
		rx_val = v;
		-> rx_ev;
	endtask
	// Delay field: lets the device finish its access
	task automatic gap();
		#200;
	endtask
	// Long low, release, then time the answering low pulse
	task automatic sync(output logic [15:0] len);
		time t0;
		pod_low = 1'b1;
		#1500 pod_low = 1'b0;
		@(negedge line) t0 = $time;
		@(posedge line) len = 16'(($time - t0) / 10);
	endtask
endmodule

// file: testbench.sv
// Self-checking bench: pod sends commands, stubs stand for CPU and memory
// Assumes a pulled-up debug line and memory data one cycle after a read
`timescale 1ns/10ps
module testbench;
	logic sys_clk, arst_n, cpu_halted;
	logic [7:0] cpu_acc, cpu_flags, ctrl;
	logic [7:0] mem_rdata = 8'h00;
	logic [15:0] cpu_pc, cpu_index, cpu_sp, a, d, t;
	logic [15:0] rv[5];
	logic [7:0] rc[5] = '{8'h68, 8'h69, 8'h6b, 8'h6c, 8'h6f};
	logic [7:0] mc[3] = '{8'h08, 8'h18, 8'h10};
	wire line_out, line_oe, pod_low, reg_wr, bgnd_req, go_req, step_req, mem_rd, mem_wr, ack_enable;
	wire [2:0] reg_sel;
	wire [15:0] reg_wdata, mem_addr, debug_breakpoint_match;
	wire [7:0] mem_wdata, debug_status_control;
	// Pull-up wins whenever nobody drives
	wire line = line_oe ? line_out : !pod_low;
	int fails = 0;
	int n_compared = 0;
	logic [35:0] ev_q[$];
	logic [15:0] rx_q[$];
	bgdp_cmd DUT (.sys_clk, .arst_n, .line_in(line), .line_out, .line_oe, .cpu_halted, .cpu_acc, .cpu_flags,
		.cpu_pc, .cpu_index, .cpu_sp, .reg_wr, .reg_sel, .reg_wdata, .bgnd_req, .go_req, .step_req, .mem_addr,
		.mem_wdata, .mem_rd, .mem_wr, .mem_rdata, .ack_enable, .debug_status_control, .debug_breakpoint_match);
	bgdp_pod P (.line, .pod_low);
	function automatic logic [15:0] mf(input logic [15:0] x);
		return {8'h00, x[7:0] ^ x[15:8] ^ 8'h3c};
	endfunction
	function automatic logic [15:0] st();
		return {8'h00, ctrl[7], cpu_halted, ctrl[5:0]};
	endfunction
	task automatic chk_val(input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic chk_evt(input logic [35:0] g);
		logic [35:0] e;
		e = ev_q.size() ? ev_q.pop_front() : '1;
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic rd(input logic [15:0] e, input int n);
		rx_q.push_back(e);
		P.recv(n);
	endtask
	task automatic halt(input logic h);
		@(negedge sys_clk) cpu_halted = h;
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Memory stub answers the cycle after a read strobe
	always @(negedge sys_clk) if (mem_rd) mem_rdata <= 8'(mf(mem_addr));
	// Every strobe takes the oldest noted expectation
	always @(posedge sys_clk) begin
		if (reg_wr) chk_evt({4'h2, 13'h0, reg_sel, reg_sel < 3'h2 ? {8'h00, reg_wdata[7:0]} : reg_wdata});
		if (mem_rd) chk_evt({4'h3, mem_addr, 16'h0000});
		if (mem_wr) chk_evt({4'h1, mem_addr, 8'h00, mem_wdata});
		if (bgnd_req | go_req | step_req) chk_evt({4'h4, 29'h0, bgnd_req, go_req, step_req});
	end
	always @(P.rx_ev) chk_val(rx_q.pop_front(), P.rx_val);
	initial begin
		#900000;
		fails++;
		finish_test();
	end
	initial begin
		void'($urandom(32'h0884e008));
		foreach (rv[i]) rv[i] = $urandom;
		rv[0][15:8] = 8'h00;
		rv[1][15:8] = 8'h00;
		{cpu_acc, cpu_flags, cpu_pc, cpu_index, cpu_sp} = {rv[0][7:0], rv[1][7:0], rv[2], rv[3], rv[4]};
		arst_n = 1'b0;
		cpu_halted = 1'b0;
		ctrl = 8'h00;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk) arst_n = 1'b1;
		chk_val({line_oe, ack_enable, debug_status_control}, 16'h0000);
		chk_val(debug_breakpoint_match, 16'h0000);
		repeat (3) @(negedge sys_clk);
		// Halt request ignored while disabled; halted-only codes ignored while running
		foreach (mc[i]) begin
			P.send(i ? mc[i] : 8'h90, 8);
			#6000;
		end
		P.send(8'he4, 8);
		rd(st(), 8);
		ctrl = 8'h80 | (8'($urandom) & 8'h3f);
		P.send(8'hc4, 8);
		P.send(ctrl, 8);
		#100 chk_val(debug_status_control, ctrl);
		ev_q.push_back(36'h400000004);
		P.send(8'h90, 8);
		P.gap();
		for (int k = 0; k < 2; k++) begin
			P.send(8'hd5 + k, 8);
			P.gap();
			chk_val(ack_enable, 16'(!k));
		end
		d = $urandom;
		P.send(8'hc2, 8);
		P.send(d, 16);
		#100 chk_val(debug_breakpoint_match, d);
		P.send(8'he2, 8);
		rd(d, 16);
		// Memory access while running, second pass with a slow host
		for (int k = 0; k < 2; k++) begin
			P.slow = k * 300;
			a = $urandom;
			d = {8'h00, 8'($urandom)};
			ev_q.push_back({4'h1, a, d});
			P.send(8'hc0 | k, 8);
			P.send(a, 16);
			P.send(d, 8);
			P.gap();
			if (k) rd(st(), 8);
			ev_q.push_back({4'h3, a, 16'h0000});
			P.send(8'he0 | k, 8);
			P.send(a, 16);
			P.gap();
			if (k) rd(st(), 8);
			rd(mf(a), 8);
		end
		P.slow = 0;
		ev_q.push_back({4'h3, a, 16'h0000});
		P.send(8'he8, 8);
		rd(st(), 8);
		rd(mf(a), 8);
		halt(1'b1);
		foreach (rc[i]) begin
			P.send(rc[i], 8);
			P.gap();
			rd(rv[i], i < 2 ? 8 : 16);
			d = $urandom;
			if (i < 2) d[15:8] = 8'h00;
			ev_q.push_back({4'h2, 13'h0, 3'(i), d});
			P.send(rc[i] - 8'h20, 8);
			P.send(d, i < 2 ? 8 : 16);
			P.gap();
		end
		t = cpu_index + 16'h0001;
		for (int k = 0; k < 2; k++) begin
			ev_q.push_back({4'h2, 16'h0003, t});
			ev_q.push_back({4'h3, t, 16'h0000});
			P.send(8'h70 | k, 8);
			P.gap();
			if (k) rd(st(), 8);
			rd(mf(t), 8);
			d = {8'h00, 8'($urandom)};
			ev_q.push_back({4'h2, 16'h0003, t});
			ev_q.push_back({4'h1, t, d});
			P.send(8'h50 | k, 8);
			P.send(d, 8);
			P.gap();
			if (k) rd(st(), 8);
		end
		foreach (mc[i]) begin
			ev_q.push_back({4'h4, 29'h0, mc[i] == 8'h10 ? 3'h1 : 3'h2});
			P.send(mc[i], 8);
			P.gap();
		end
		// Half an address then silence; a live write would swallow the next code
		P.send(8'hc0, 8);
		P.send(8'h12, 8);
		#6000;
		P.send(8'he4, 8);
		rd(st(), 8);
		// Speed request in mid-command: abort, then the reference pulse
		P.send(8'he0, 8);
		P.sync(t);
		@(negedge sys_clk) chk_val(t, 16'h0080);
		P.send(8'he4, 8);
		rd(st(), 8);
		#500 chk_val(16'(ev_q.size() + rx_q.size()), 16'h0000);
		finish_test();
	end
endmodule
